/* File: design/apr_axis.v */
`timescale 1ns/100ps
`default_nettype none
`include "apr_map.vh"
module apr_axis (
	// clock
	input  wire        core_clk,
	input  wire        clk_en,
	input  wire        resetn,
	// host access
	input  wire        wr_en,
	input  wire [3:0]  wr_idx,
	input  wire [23:0] wr_data,
	input  wire [3:0]  rd_idx,
	output reg  [23:0] rd_data,
	// core side
	input  wire [23:0] core_position,
	input  wire        core_pos_valid,
	input  wire [11:0] core_speed,
	input  wire [11:0] core_accel,
	input  wire [11:0] core_cmd_speed,
	input  wire        core_cmd_valid,
	input  wire [7:0]  core_seq_ptr,
	input  wire        core_seq_valid,
	input  wire [7:0]  core_irq_set,
	input  wire        ref_change,
	input  wire [1:0]  ramp_phase,
	output wire [23:0] target_position,
	output wire [23:0] current_position,
	output wire [10:0] stop_speed_floor,
	output wire [10:0] speed_ceiling,
	output wire [11:0] commanded_speed,
	output wire [11:0] present_speed,
	output wire        speed_load,
	output wire [10:0] accel_limit,
	output wire [10:0] accel_boost_threshold,
	output wire [2:0]  current_scale,
	output wire [7:0]  decel_mantissa,
	output wire [3:0]  decel_exponent,
	output wire [1:0]  motion_mode_select,
	output wire [3:0]  ref_switch_config,
	output wire [3:0]  accel_scale,
	output wire [3:0]  step_rate_scale,
	output wire [1:0]  microstep_res,
	output wire [11:0] ref_window,
	output wire [7:0]  sequencer_pointer,
	output wire        irq_pending
);
	reg  [23:0] tgt_r, cur_r, lat_r;
	reg  [10:0] vmin_r, vmax_r, amax_r, athr_r;
	reg  [11:0] vcmd_r, vpres_r, apres_r, rwin_r;
	reg  [2:0]  csa_r, csd_r, csr_r;
	reg  [7:0]  pm_r, seq_r, msk_r, flg_r;
	reg  [3:0]  pd_r, ref_r, rdiv_r, decel_exponent_r;
	reg  [1:0]  mode_r, usrs_r;
	reg         lp_r;
	wire manual = (mode_r == `APR_MODE_MANUAL);
	wire speedm = (mode_r == `APR_MODE_SPEED);
	wire wr     = wr_en & clk_en;

	////////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		if (!resetn) begin
			tgt_r <= `APR_RESET_VALUE; cur_r <= `APR_RESET_VALUE; lat_r <= `APR_RESET_VALUE;
			vmin_r <= 11'h000; vmax_r <= 11'h000; amax_r <= 11'h000; athr_r <= 11'h000;
			vcmd_r <= 12'h000; vpres_r <= 12'h000; apres_r <= 12'h000; rwin_r <= 12'h000;
			csa_r <= 3'h0; csd_r <= 3'h0; csr_r <= 3'h0;
			pm_r <= 8'h00; seq_r <= 8'h00; msk_r <= 8'h00; flg_r <= 8'h00;
			pd_r <= 4'h0; ref_r <= 4'h0; rdiv_r <= 4'h0; decel_exponent_r <= 4'h0;
			mode_r <= 2'h0; usrs_r <= 2'h0; lp_r <= 1'b0;
		end else if (clk_en) begin
			apres_r <= core_accel;
			// speed written only in manual mode
			if (!(wr && wr_idx == `APR_IDX_PRES_SPEED && manual))
				vpres_r <= core_speed;
			// host write wins over core position update
			if (core_pos_valid)
				cur_r <= core_position;
			if (core_cmd_valid && !speedm && !manual)
				vcmd_r <= core_cmd_speed;
			if (core_seq_valid)
				seq_r <= core_seq_ptr;
			if (ref_change) begin
				lat_r <= cur_r;
				lp_r  <= 1'b1;
			end
			if (wr) begin
				case (wr_idx)
				`APR_IDX_TARGET_POS:  tgt_r <= wr_data;
				`APR_IDX_CURRENT_POS: cur_r <= wr_data;
				`APR_IDX_STOP_FLOOR:  vmin_r <= wr_data[10:0];
				`APR_IDX_SPEED_CEIL:  vmax_r <= wr_data[10:0];
				`APR_IDX_CMD_SPEED:   vcmd_r <= wr_data[11:0];
				`APR_IDX_PRES_SPEED: begin
					if (manual)
						vpres_r <= wr_data[11:0];
				end
				`APR_IDX_ACCEL:       amax_r <= wr_data[10:0];
				`APR_IDX_CUR_SCALE: begin
					csa_r  <= wr_data[`APR_CS_ACCEL_LO+2:`APR_CS_ACCEL_LO];
					csd_r  <= wr_data[`APR_CS_DECEL_LO+2:`APR_CS_DECEL_LO];
					csr_r  <= wr_data[`APR_CS_REST_LO+2:`APR_CS_REST_LO];
					athr_r <= wr_data[10:0];
				end
				`APR_IDX_DECEL_FACT: begin
					pm_r <= wr_data[`APR_DF_MANT_LO+7:`APR_DF_MANT_LO];
					pd_r <= wr_data[3:0];
				end
				`APR_IDX_MODE_REF: begin
					mode_r <= wr_data[1:0];
					ref_r  <= wr_data[`APR_MR_REF_LO+3:`APR_MR_REF_LO];
				end
				`APR_IDX_IRQ:         msk_r <= wr_data[`APR_IRQ_MASK_LO+7:`APR_IRQ_MASK_LO];
				`APR_IDX_DIVIDERS: begin
					rdiv_r <= wr_data[`APR_DV_ACCEL_LO+3:`APR_DV_ACCEL_LO];
					decel_exponent_r <= wr_data[`APR_DV_STEP_LO+3:`APR_DV_STEP_LO];
					usrs_r <= wr_data[1:0];
				end
				`APR_IDX_REF_WINDOW:  rwin_r <= wr_data[11:0];
				`APR_IDX_SEQ_PTR:     seq_r <= wr_data[7:0];
				default: ;
				endcase
			end
			// flags: write one clears, set wins
			if (wr && wr_idx == `APR_IDX_IRQ)
				flg_r <= (flg_r & ~wr_data[7:0]) | core_irq_set;
			else
				flg_r <= flg_r | core_irq_set;
		end
	end

	////////////////////////////////////////////////////////////////////
	// unused upper bits zero
	always @* begin
		case (rd_idx)
		`APR_IDX_TARGET_POS:  rd_data = tgt_r;
		`APR_IDX_CURRENT_POS: rd_data = cur_r;
		`APR_IDX_STOP_FLOOR:  rd_data = {13'h0000, vmin_r};
		`APR_IDX_SPEED_CEIL:  rd_data = {13'h0000, vmax_r};
		`APR_IDX_CMD_SPEED:   rd_data = {12'h000, vcmd_r};
		`APR_IDX_PRES_SPEED:  rd_data = {12'h000, vpres_r};
		`APR_IDX_ACCEL:       rd_data = {1'b0, apres_r, amax_r};
		`APR_IDX_CUR_SCALE:   rd_data = {1'b0, csa_r, 1'b0, csd_r, 1'b0, csr_r, 1'b0, athr_r};
		`APR_IDX_DECEL_FACT:  rd_data = {8'h00, pm_r, 4'h0, pd_r};
		`APR_IDX_MODE_REF:    rd_data = {7'h00, lp_r, 4'h0, ref_r, 6'h00, mode_r};
		`APR_IDX_IRQ:         rd_data = {8'h00, msk_r, flg_r};
		`APR_IDX_DIVIDERS:    rd_data = {8'h00, decel_exponent_r, rdiv_r, 6'h00, usrs_r};
		`APR_IDX_REF_WINDOW:  rd_data = {12'h000, rwin_r};
		`APR_IDX_LATCHED_POS: rd_data = lat_r;
		`APR_IDX_SEQ_PTR:     rd_data = {16'h0000, seq_r};
		default:              rd_data = 24'h000000;
		endcase
	end

	assign target_position       = tgt_r;
	assign current_position      = cur_r;
	assign stop_speed_floor      = vmin_r;
	assign speed_ceiling         = vmax_r;
	assign commanded_speed       = vcmd_r;
	assign present_speed         = vpres_r;
	assign speed_load            = wr && wr_idx == `APR_IDX_PRES_SPEED && manual;
	assign accel_limit           = amax_r;
	assign accel_scale           = rdiv_r;
	assign step_rate_scale       = decel_exponent_r;
	assign accel_boost_threshold = athr_r;
	assign current_scale         = (ramp_phase == 2'h1) ? csa_r : (ramp_phase == 2'h2) ? csd_r : csr_r;
	assign decel_mantissa        = pm_r;
	assign decel_exponent        = pd_r;
	assign motion_mode_select    = mode_r;
	assign ref_switch_config     = ref_r;
	assign microstep_res         = usrs_r;
	assign ref_window            = rwin_r;
	assign sequencer_pointer     = seq_r;
	assign irq_pending           = |(flg_r & msk_r);
endmodule // apr_axis
`default_nettype wire

/* File: design/apr_map.vh */
`ifndef APR_MAP_VH
`define APR_MAP_VH
// register index within one axis set
`define APR_IDX_TARGET_POS   4'h0
`define APR_IDX_CURRENT_POS  4'h1
`define APR_IDX_STOP_FLOOR   4'h2
`define APR_IDX_SPEED_CEIL   4'h3
`define APR_IDX_CMD_SPEED    4'h4
`define APR_IDX_PRES_SPEED   4'h5
`define APR_IDX_ACCEL        4'h6
`define APR_IDX_CUR_SCALE    4'h8
`define APR_IDX_DECEL_FACT   4'h9
`define APR_IDX_MODE_REF     4'ha
`define APR_IDX_IRQ          4'hb
`define APR_IDX_DIVIDERS     4'hc
`define APR_IDX_REF_WINDOW   4'hd
`define APR_IDX_LATCHED_POS  4'he
`define APR_IDX_SEQ_PTR      4'hf
// motion modes
`define APR_MODE_RAMP        2'h0
`define APR_MODE_SOFT        2'h1
`define APR_MODE_SPEED       2'h2
`define APR_MODE_MANUAL      2'h3
// datagram field positions
`define APR_DG_AXIS_HI       30
`define APR_DG_AXIS_LO       29
`define APR_DG_IDX_HI        28
`define APR_DG_IDX_LO        25
`define APR_DG_RW_BIT        24
// field positions inside packed words
`define APR_CS_ACCEL_LO      20
`define APR_CS_DECEL_LO      16
`define APR_CS_REST_LO       12
`define APR_DF_MANT_LO       8
`define APR_MR_REF_LO        8
`define APR_MR_LATCH_BIT     16
`define APR_IRQ_MASK_LO      8
`define APR_DV_ACCEL_LO      8
`define APR_DV_STEP_LO       12
`define APR_RESET_VALUE      24'h000000
`endif

/* File: design/apr_sync.v */
`timescale 1ns/100ps
`default_nettype none
module apr_sync (
	// clock
	input  wire core_clk,
	input  wire clk_en,
	input  wire resetn,
	// signal
	input  wire async_in,
	output wire sync_out
);
	reg meta_r;
	reg sync_r;
	always @(posedge core_clk) begin
		if (!resetn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else if (clk_en) begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end
	assign sync_out = sync_r;
endmodule // apr_sync
`default_nettype wire

/* File: design/apr_regs.v */
// Operation
// - two-bit mode field per axis picks one of four modes
// - register meaning depends on the selected mode
// - present speed read-only except in manual ramp mode
// - target and current positions are 24-bit writable values
// - 11-bit stop speed floor for abrupt stop
// - 11-bit speed ceiling limits absolute speed
// - 12-bit signed commanded speed, use depends on mode
// - 11-bit acceleration limit from 0 to 2047
// - 12-bit signed present acceleration, read only
// - three 3-bit current scales chosen by ramp phase
// - mantissa and exponent form deceleration factor
// - four-bit reference switch configuration per axis
// - read-only latched-position status bit
// - eight interrupt flags and eight-bit mask per axis
// - acceleration limit scaled by four-bit prescaler
// - four-bit step rate scale sets pulse clock
// - two-bit microstep resolution field
// - 12-bit reference window excludes motion range
// - switch change copies current position into latched position
// - eight-bit sequencer pointer readable and writable
// - all bits cleared at reset
// - writing zero speed in manual mode stops at once
// - datagram read/write bit: zero writes, one reads
`timescale 1ns/100ps
`default_nettype none
`include "apr_map.vh"
module apr_regs #(
	parameter NUM_AXES = 3
) (
	// clock and reset
	input  wire                   core_clk,
	input  wire                   clk_en,
	input  wire                   resetn,
	// host datagram
	input  wire                   dg_valid,
	input  wire [31:0]            dg_word,
	output reg  [23:0]            dg_rdata,
	output reg                    dg_rvalid,
	// reference switch pins
	input  wire [NUM_AXES-1:0]    ref_switch_pin,
	// core side, packed per axis
	input  wire [NUM_AXES*24-1:0] core_position,
	input  wire [NUM_AXES-1:0]    core_pos_valid,
	input  wire [NUM_AXES*12-1:0] core_speed,
	input  wire [NUM_AXES*12-1:0] core_accel,
	input  wire [NUM_AXES*12-1:0] core_cmd_speed,
	input  wire [NUM_AXES-1:0]    core_cmd_valid,
	input  wire [NUM_AXES*8-1:0]  core_seq_ptr,
	input  wire [NUM_AXES-1:0]    core_seq_valid,
	input  wire [NUM_AXES*8-1:0]  core_irq_set,
	input  wire [NUM_AXES*2-1:0]  ramp_phase,
	output wire [NUM_AXES*24-1:0] target_position,
	output wire [NUM_AXES*24-1:0] current_position,
	output wire [NUM_AXES*11-1:0] stop_speed_floor,
	output wire [NUM_AXES*11-1:0] speed_ceiling,
	output wire [NUM_AXES*12-1:0] commanded_speed,
	output wire [NUM_AXES*12-1:0] present_speed,
	output wire [NUM_AXES-1:0]    speed_load,
	output wire [NUM_AXES*11-1:0] accel_limit,
	output wire [NUM_AXES*11-1:0] accel_boost_threshold,
	output wire [NUM_AXES*3-1:0]  current_scale,
	output wire [NUM_AXES*8-1:0]  decel_mantissa,
	output wire [NUM_AXES*4-1:0]  decel_exponent,
	output wire [NUM_AXES*2-1:0]  motion_mode_select,
	output wire [NUM_AXES*4-1:0]  ref_switch_config,
	output wire [NUM_AXES*4-1:0]  accel_scale,
	output wire [NUM_AXES*4-1:0]  step_rate_scale,
	output wire [NUM_AXES*2-1:0]  microstep_res,
	output wire [NUM_AXES*12-1:0] ref_window,
	output wire [NUM_AXES*8-1:0]  sequencer_pointer,
	output wire [NUM_AXES-1:0]    irq_pending
);
	wire [1:0]  axis_sel = dg_word[`APR_DG_AXIS_HI:`APR_DG_AXIS_LO];
	wire [3:0]  idx      = dg_word[`APR_DG_IDX_HI:`APR_DG_IDX_LO];
	wire        is_write = dg_valid & ~dg_word[`APR_DG_RW_BIT];
	wire        is_read  = dg_valid & dg_word[`APR_DG_RW_BIT];
	wire [NUM_AXES*24-1:0] rd_all;
	reg  [NUM_AXES-1:0]    sw_prev_r;
	wire [NUM_AXES-1:0]    sw_sync;

	////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < NUM_AXES; g = g + 1) begin : g_axis
			apr_sync u_sync (
				.core_clk (core_clk),
				.clk_en   (clk_en),
				.resetn   (resetn),
				.async_in (ref_switch_pin[g]),
				.sync_out (sw_sync[g])
			);
			apr_axis u_axis (
				.core_clk              (core_clk),
				.clk_en                (clk_en),
				.resetn                (resetn),
				.wr_en                 (is_write && axis_sel == g),
				.wr_idx                (idx),
				.wr_data               (dg_word[23:0]),
				.rd_idx                (idx),
				.rd_data               (rd_all[g*24 +: 24]),
				.core_position         (core_position[g*24 +: 24]),
				.core_pos_valid        (core_pos_valid[g]),
				.core_speed            (core_speed[g*12 +: 12]),
				.core_accel            (core_accel[g*12 +: 12]),
				.core_cmd_speed        (core_cmd_speed[g*12 +: 12]),
				.core_cmd_valid        (core_cmd_valid[g]),
				.core_seq_ptr          (core_seq_ptr[g*8 +: 8]),
				.core_seq_valid        (core_seq_valid[g]),
				.core_irq_set          (core_irq_set[g*8 +: 8]),
				.ref_change            (sw_sync[g] ^ sw_prev_r[g]),
				.ramp_phase            (ramp_phase[g*2 +: 2]),
				.target_position       (target_position[g*24 +: 24]),
				.current_position      (current_position[g*24 +: 24]),
				.stop_speed_floor      (stop_speed_floor[g*11 +: 11]),
				.speed_ceiling         (speed_ceiling[g*11 +: 11]),
				.commanded_speed       (commanded_speed[g*12 +: 12]),
				.present_speed         (present_speed[g*12 +: 12]),
				.speed_load            (speed_load[g]),
				.accel_limit           (accel_limit[g*11 +: 11]),
				.accel_boost_threshold (accel_boost_threshold[g*11 +: 11]),
				.current_scale         (current_scale[g*3 +: 3]),
				.decel_mantissa        (decel_mantissa[g*8 +: 8]),
				.decel_exponent        (decel_exponent[g*4 +: 4]),
				.motion_mode_select    (motion_mode_select[g*2 +: 2]),
				.ref_switch_config     (ref_switch_config[g*4 +: 4]),
				.accel_scale           (accel_scale[g*4 +: 4]),
				.step_rate_scale       (step_rate_scale[g*4 +: 4]),
				.microstep_res         (microstep_res[g*2 +: 2]),
				.ref_window            (ref_window[g*12 +: 12]),
				.sequencer_pointer     (sequencer_pointer[g*8 +: 8]),
				.irq_pending           (irq_pending[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// read data registered; common-register axis code reads zero here
	always @(posedge core_clk) begin
		if (!resetn) begin
			dg_rdata  <= 24'h000000;
			dg_rvalid <= 1'b0;
			sw_prev_r <= {NUM_AXES{1'b0}};
		end else if (clk_en) begin
			sw_prev_r <= sw_sync;
			dg_rvalid <= is_read;
			if (is_read)
				dg_rdata <= (axis_sel < NUM_AXES) ? rd_all[axis_sel*24 +: 24] : 24'h000000;
		end
	end
endmodule // apr_regs
`default_nettype wire

/* File: sim/apr_regs_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module apr_regs_checker #(
	parameter NUM_AXES = 3
) (
	// clock and reset
	input wire logic                   core_clk,
	input wire logic                   clk_en,
	input wire logic                   resetn,
	// host datagram
	input wire logic                   dg_valid,
	input wire logic [31:0]            dg_word,
	input wire logic                   dg_rvalid,
	// register fields
	input wire logic [NUM_AXES*24-1:0] target_position,
	input wire logic [NUM_AXES*11-1:0] speed_ceiling,
	input wire logic [NUM_AXES*12-1:0] present_speed,
	input wire logic [NUM_AXES*2-1:0]  motion_mode_select,
	input wire logic [NUM_AXES-1:0]    irq_pending
);
	logic       rd_take;
	logic       wr_take;
	logic [5:0] sel;
	logic       was_reset_r;
	assign rd_take = clk_en & dg_valid & dg_word[24];
	assign wr_take = clk_en & dg_valid & ~dg_word[24];
	assign sel = dg_word[30:25];
	// remembers a reset edge so the first free cycle can be checked
	always @(posedge core_clk) begin
		was_reset_r <= ~resetn & clk_en;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////////////
	a_read_answer: assert property (rd_take |=> dg_rvalid)
		else $error("read datagram got no answer");
	a_no_stray_answer: assert property (clk_en && !rd_take |=> !dg_rvalid)
		else $error("answer without a read");
	a_reset_clear: assert property (was_reset_r |-> target_position == '0 && motion_mode_select == '0 && !dg_rvalid)
		else $error("state not cleared by reset");
	a_target_load: assert property (wr_take && sel == 6'h00 |=> target_position[23:0] == $past(dg_word[23:0]))
		else $error("target position not loaded");
	a_speed_guard: assert property (wr_take && sel == 6'h05 && motion_mode_select[1:0] != 2'h3
		|=> $stable(present_speed[11:0]))
		else $error("speed written outside manual mode");
	a_manual_speed: assert property (wr_take && sel == 6'h05 && motion_mode_select[1:0] == 2'h3
		|=> present_speed[11:0] == $past(dg_word[11:0]))
		else $error("manual speed not loaded");
	a_mode_load: assert property (wr_take && sel == 6'h1a |=> motion_mode_select[3:2] == $past(dg_word[1:0]))
		else $error("mode not loaded");
	a_ceiling_load: assert property (wr_take && sel == 6'h23 |=> speed_ceiling[32:22] == $past(dg_word[10:0]))
		else $error("speed ceiling not loaded");
	a_common_ignored: assert property (wr_take && sel[5:4] == 2'h3
		|=> $stable(target_position) && $stable(speed_ceiling) && $stable(motion_mode_select))
		else $error("common axis write changed a register");
	c_read: cover property (rd_take);
	c_manual: cover property (wr_take && sel == 6'h05 && motion_mode_select[1:0] == 2'h3);
	c_irq: cover property (irq_pending != '0);
endmodule // apr_regs_checker
bind apr_regs apr_regs_checker #(.NUM_AXES(NUM_AXES)) u_checker (
	.core_clk(core_clk), .clk_en(clk_en), .resetn(resetn), .dg_valid(dg_valid), .dg_word(dg_word),
	.dg_rvalid(dg_rvalid), .target_position(target_position), .speed_ceiling(speed_ceiling),
	.present_speed(present_speed), .motion_mode_select(motion_mode_select), .irq_pending(irq_pending)
);
`default_nettype wire

/* File: sim/apr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module apr_host_model (
	// clock
	input  wire logic        core_clk,
	// datagram
	output var  logic        dg_valid,
	output var  logic [31:0] dg_word,
	input  wire logic [23:0] dg_rdata,
	input  wire logic        dg_rvalid
);
	initial begin
		dg_valid = 1'b0;
		dg_word = 32'h00000000;
	end
	// word scrambled once released so nothing can lean on a stale value
	task automatic xfer(input logic [1:0] ax, input logic [3:0] idx, input logic rd,
		input logic [23:0] d, output logic [23:0] q);
		@(posedge core_clk) #1;
		dg_valid = 1'b1;
		dg_word = {1'b0, ax, idx, rd, d};
		@(posedge core_clk) #1;
		dg_valid = 1'b0;
		dg_word = ~dg_word;
		// the answer stands only in the cycle after the taking edge
		q = rd ? (dg_rvalid ? dg_rdata : 24'hxxxxxx) : 24'h000000;
	endtask
endmodule // apr_host_model
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHECK_EQ(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin errors++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb_top;
	logic        core_clk, clk_en, resetn, dg_valid, dg_rvalid;
	logic [31:0] dg_word;
	logic [23:0] dg_rdata, q, d, p, core_seq_ptr, core_irq_set;
	logic [2:0]  ref_switch_pin, core_pos_valid, core_seq_valid, irq_pending, speed_load;
	logic [35:0] core_speed;
	logic [71:0] core_position;
	logic [5:0]  ramp_phase;
	logic [8:0]  current_scale;
	integer      errors, comparisons, cycles, seed, i, a, x;
	apr_host_model host (.core_clk(core_clk), .dg_valid(dg_valid), .dg_word(dg_word),
		.dg_rdata(dg_rdata), .dg_rvalid(dg_rvalid));
	apr_regs #(.NUM_AXES(3)) dut (
		.core_clk(core_clk), .clk_en(clk_en), .resetn(resetn), .dg_valid(dg_valid), .dg_word(dg_word),
		.dg_rdata(dg_rdata), .dg_rvalid(dg_rvalid), .ref_switch_pin(ref_switch_pin),
		.core_position(core_position), .core_pos_valid(core_pos_valid), .core_speed(core_speed),
		.core_accel(36'h000000000), .core_cmd_speed(36'h000000000), .core_cmd_valid(3'h0),
		.core_seq_ptr(core_seq_ptr), .core_seq_valid(core_seq_valid), .core_irq_set(core_irq_set),
		.ramp_phase(ramp_phase), .target_position(), .current_position(), .stop_speed_floor(),
		.speed_ceiling(), .commanded_speed(), .present_speed(), .speed_load(speed_load), .accel_limit(),
		.accel_boost_threshold(), .current_scale(current_scale), .decel_mantissa(), .decel_exponent(),
		.motion_mode_select(), .ref_switch_config(), .accel_scale(), .step_rate_scale(),
		.microstep_res(), .ref_window(), .sequencer_pointer(), .irq_pending(irq_pending)
	);
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [23:0] rw_mask(input logic [3:0] idx);
		case (idx)
			4'h0, 4'h1: rw_mask = 24'hffffff;
			4'h2, 4'h3, 4'h6: rw_mask = 24'h0007ff;
			4'h4, 4'hd: rw_mask = 24'h000fff;
			4'h8: rw_mask = 24'h7777ff;
			4'h9: rw_mask = 24'h00ff0f;
			4'ha: rw_mask = 24'h000f03;
			4'hb: rw_mask = 24'h00ff00;
			4'hc: rw_mask = 24'h00ff03;
			4'hf: rw_mask = 24'h0000ff;
			default: rw_mask = 24'h000000;
		endcase
	endfunction
	function automatic logic [2:0] scale_exp(input int ph);
		scale_exp = (ph == 1) ? 3'h5 : (ph == 2) ? 3'h3 : 3'h6;
	endfunction
	task automatic wr(input int ax, input int idx, input logic [23:0] v);
		host.xfer(ax[1:0], idx[3:0], 1'b0, v, q);
	endtask
	task automatic rd(input int ax, input int idx);
		host.xfer(ax[1:0], idx[3:0], 1'b1, 24'h000000, q);
	endtask
	task automatic stop_test;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// stands in for the ramp core: it takes over a speed the host loads in manual mode
	always @(posedge core_clk) begin
		for (int k = 0; k < 3; k++)
			if (speed_load[k])
				core_speed[k*12 +: 12] <= dg_word[11:0];
	end
	// a hung handshake would otherwise stall the run
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			stop_test();
		end
	end
	initial begin
		seed = 32'h5c04fc6e;
		errors = 0;
		comparisons = 0;
		cycles = 0;
		clk_en = 1'b1;
		resetn = 1'b0;
		ref_switch_pin = 3'h0;
		core_pos_valid = 3'h0;
		core_seq_valid = 3'h0;
		core_position = 72'h0;
		core_speed = 36'h000000000;
		core_seq_ptr = 24'h000000;
		core_irq_set = 24'h000000;
		ramp_phase = 6'h00;
		repeat (8) @(posedge core_clk);
		#1 resetn = 1'b1;
		for (a = 0; a < 4; a++)
			for (x = 0; x < 16; x++) begin
				rd(a, x);
				`CHECK_EQ("reset value", 24'h000000, q)
			end
		for (i = 0; i < 80; i++) begin
			a = {$random(seed)} % 4;
			x = {$random(seed)} % 16;
			d = 24'($random(seed));
			if (x == 5)
				x = 4;
			wr(a, x, d);
			rd(a, x);
			`CHECK_EQ("field readback", (a == 3) ? 24'h000000 : d & rw_mask(x[3:0]), q)
		end
		for (i = 0; i < 4; i++) begin
			wr(0, 10, i[23:0]);
			wr(0, 5, 24'h0005a5);
			rd(0, 5);
			`CHECK_EQ("speed write", (i == 3) ? 24'h0005a5 : 24'h000000, q)
		end
		wr(0, 5, 24'h000000);
		rd(0, 5);
		`CHECK_EQ("speed stop", 24'h000000, q)
		// a write while the clock enable is low must be lost
		wr(0, 13, 24'h000123);
		clk_en = 1'b0;
		wr(0, 13, 24'h000abc);
		clk_en = 1'b1;
		rd(0, 13);
		`CHECK_EQ("frozen write", 24'h000123, q)
		wr(1, 10, 24'h000002);
		p = 24'($random(seed));
		wr(1, 1, p);
		ref_switch_pin[1] = 1'b1;
		repeat (6) @(posedge core_clk);
		rd(1, 14);
		`CHECK_EQ("latched position", p, q)
		rd(1, 10);
		`CHECK_EQ("latched flag", 24'h010002, q)
		p = 24'($random(seed));
		@(posedge core_clk) #1;
		core_position[47:24] = p;
		core_seq_ptr[15:8] = 8'h9c;
		core_pos_valid = 3'h2;
		core_seq_valid = 3'h2;
		@(posedge core_clk) #1;
		core_pos_valid = 3'h0;
		core_seq_valid = 3'h0;
		rd(1, 1);
		`CHECK_EQ("core position", p, q)
		rd(1, 15);
		`CHECK_EQ("sequencer pointer", 24'h00009c, q)
		wr(2, 11, 24'h00a500);
		wr(2, 3, 24'h0007ff);
		core_irq_set[23:16] = 8'h3c;
		@(posedge core_clk) #1;
		core_irq_set[23:16] = 8'h00;
		rd(2, 11);
		`CHECK_EQ("irq flags", 24'h00a53c, q)
		`CHECK_EQ("irq pending", 3'h4, irq_pending)
		wr(2, 11, 24'h00a53c);
		rd(2, 11);
		`CHECK_EQ("irq cleared", 24'h00a500, q)
		`CHECK_EQ("irq idle", 3'h0, irq_pending)
		wr(0, 0, 24'h800001);
		wr(0, 8, 24'h536000);
		for (i = 0; i < 4; i++) begin
			@(posedge core_clk) #1;
			ramp_phase[1:0] = i[1:0];
			@(negedge core_clk);
			`CHECK_EQ("current scale", scale_exp(i), current_scale[2:0])
		end
		// second reset in mid-run must clear what the host wrote
		@(posedge core_clk) #1 resetn = 1'b0;
		repeat (2) @(posedge core_clk);
		#1 resetn = 1'b1;
		rd(0, 0);
		`CHECK_EQ("reset target", 24'h000000, q)
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
